// ===== core/t16r_defs.vh
`ifndef T16R_DEFS_VH
`define T16R_DEFS_VH

// register indices on the bus; byte address = 4 * index
`define T16R_IDX_INTCTL 8'h0b
`define T16R_IDX_PFLAG 8'h0c
`define T16R_IDX_CNTLO 8'h0e
`define T16R_IDX_CNTHI 8'h0f
`define T16R_IDX_TCTL 8'h10
`define T16R_IDX_PEN 8'h8c
`define T16R_IDX_TRIG 8'h90

// timer control fields
`define T16R_TCTL_ON 0
`define T16R_TCTL_CS 1
`define T16R_TCTL_NSYNC 2
`define T16R_TCTL_OSCEN 3
`define T16R_TCTL_PS_LO 4
`define T16R_TCTL_PS_HI 5
`define T16R_TCTL_MASK 8'h3f
`define T16R_TCTL_RST 8'h00

// interrupt bits
`define T16R_PFLAG_OVF 0
`define T16R_PEN_OVF 0
`define T16R_INTCTL_GLOBAL_EN 7
`define T16R_INTCTL_PERIPH_EN 6
`define T16R_PFLAG_RST 8'h00
`define T16R_PEN_RST 8'h00
`define T16R_INTCTL_RST 8'h00

// trigger mode register fields (unit a at 3:0, unit b at 7:4)
`define T16R_MODE_SPECIAL 4'hb
`define T16R_TRIG_RST 8'h00

// instruction cycle = 4 clocks
`define T16R_ICYC_DIV 2'h3

`endif

// ===== core/t16r_prescaler.v
`timescale 1ns/100ps
// divides qualified input ticks by 1, 2, 4 or 8
module t16r_prescaler
(
    input wire clk_i,
    input wire rst_i,
    input wire clr_i,
    input wire tick_i,
    input wire [1:0] ratio_i,
    output wire tick_o
);

reg [2:0] pcnt_r;
reg [2:0] mask;

// ratio decode: mask of low count bits that must all be ones
always @*
begin
    case (ratio_i)
        2'h0: mask = 3'h0;
        2'h1: mask = 3'h1;
        2'h2: mask = 3'h3;
        default: mask = 3'h7;
    endcase
end

assign tick_o = tick_i && ((pcnt_r & mask) == mask);

// counter cleared by count-byte writes; ratio setting untouched
always @(posedge clk_i)
begin
    if (rst_i || clr_i)
        pcnt_r <= 3'h0; // R9
    else if (tick_i)
        pcnt_r <= pcnt_r + 3'h1;
end

endmodule

// ===== core/t16r_edge_sync.v
`timescale 1ns/100ps
// external clock input: two-flop synchroniser and rising-edge detect
module t16r_edge_sync
(
    input wire clk_i,
    input wire rst_i,
    input wire ext_i,
    output wire rise_sync_o,
    output wire rise_raw_o
);

reg s1_r;
reg s2_r;
reg s3_r;
reg raw_r;

// s1 feeds only s2; a falling edge must precede the first rise
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        s1_r <= 1'b1;
        s2_r <= 1'b1;
        s3_r <= 1'b1;
        raw_r <= 1'b1;
    end
    else
    begin
        s1_r <= ext_i;
        s2_r <= s1_r;
        s3_r <= s2_r;
        raw_r <= ext_i;
    end
end

assign rise_sync_o = s2_r && !s3_r;
// unsynchronised path: a single sample, no metastability margin
assign rise_raw_o = ext_i && !raw_r;

endmodule

// ===== core/t16r_timer_core.v
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "t16r_defs.vh"
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// R1 - special-event-trigger mode on either compare unit: its match pulse clears the count
// R2 - trigger clear never sets the overflow flag
// R3 - trigger clear guaranteed only in timer or synchronised counter mode
// R4 - a count-byte write in the trigger cycle wins over the clear
// R5 - with trigger clear, count runs zero to compare pair then restarts
// R6 - count bytes survive every reset; only a trigger clears them
// R7 - power-on or brown-out reset clears the control register
// R8 - other resets leave the control register unchanged
// R9 - writing either count byte clears the prescaler counter, not the ratio
// R10 - prescale field bits 5:4 select 1:1, 1:2, 1:4, 1:8
// R11 - source select clear counts instruction cycles, set counts external rising edges
// R12 - timer-on bit 0 enables counting, clear holds the count
// R13 - in counter mode bit 2 set counts unsynchronised, clear synchronised
// R14 - rollover from all ones sets overflow flag; interrupt when enabled
// R15 - trigger clears both bytes in one cycle; counting resumes next tick
//////////////////////////////////////////////////////////////////////////////
module t16r_timer_core
(
    input wire clk_i,
    input wire rst_i,
    input wire por_bor_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    output wire wb_err_o,
    input wire ext_clk_i,
    input wire match_a_i,
    input wire match_b_i,
    output wire irq_o,
    output wire [15:0] count_o,
    output wire osc_enable_o
);

reg [7:0] count_lo_r;
reg [7:0] count_hi_r;
reg [7:0] tctl_r;
reg [7:0] pflag_r;
reg [7:0] pen_r;
reg [7:0] intctl_r;
reg [7:0] trig_r;
reg [1:0] icyc_r;
reg [7:0] rd_data;
reg hit;
wire [7:0] idx;
wire req;
wire wr;
wire wr_lo;
wire wr_hi;
wire wr_count;
wire timer_on;
wire cs_ext;
wire nsync;
wire icyc_tick;
wire rise_sync;
wire rise_raw;
wire pre_in;
wire pre_out;
wire tick;
wire [1:0] match_vec;
wire [1:0] trig_hit;
wire wr_tctl;
wire wr_pen;
wire wr_intctl;
wire wr_trig;
wire wr_pflag;
wire trig_ok;
wire trig_clear;
wire [16:0] count_inc;

//////////////////////////////////////////////////////////////////////////////
// decode helpers

// true when the index is a mapped register
function is_mapped;
    input [7:0] i;
    begin
        is_mapped = (i == `T16R_IDX_INTCTL) || (i == `T16R_IDX_PFLAG) ||
            (i == `T16R_IDX_CNTLO) || (i == `T16R_IDX_CNTHI) ||
            (i == `T16R_IDX_TCTL) || (i == `T16R_IDX_PEN) || (i == `T16R_IDX_TRIG);
    end
endfunction

// byte-lane 0 write to a given index
function wr_at;
    input [7:0] i;
    input [7:0] target;
    input w;
    begin
        wr_at = w && (i == target);
    end
endfunction

// special-event-trigger code in one unit's mode field
function is_special;
    input [3:0] mode;
    begin
        is_special = (mode == `T16R_MODE_SPECIAL);
    end
endfunction

//////////////////////////////////////////////////////////////////////////////
// wishbone slave: one wait state, ack drops the cycle after it is given

// req is masked by ack so a strobe held into the ack cycle is taken once
assign idx = wb_adr_i[9:2];
assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
assign wr = req && wb_we_i && wb_sel_i[0] && is_mapped(idx);
assign wr_lo = wr_at(idx, `T16R_IDX_CNTLO, wr);
assign wr_hi = wr_at(idx, `T16R_IDX_CNTHI, wr);
assign wr_count = wr_lo || wr_hi;
assign wb_err_o = 1'b0;

// register write strobes, byte lane 0 only
assign wr_tctl = wr_at(idx, `T16R_IDX_TCTL, wr);
assign wr_pen = wr_at(idx, `T16R_IDX_PEN, wr);
assign wr_intctl = wr_at(idx, `T16R_IDX_INTCTL, wr);
assign wr_trig = wr_at(idx, `T16R_IDX_TRIG, wr);
assign wr_pflag = wr_at(idx, `T16R_IDX_PFLAG, wr);

// unmapped addresses still ack and read zero
always @*
begin
    hit = is_mapped(idx);
    case (idx)
        `T16R_IDX_INTCTL: rd_data = intctl_r;
        `T16R_IDX_PFLAG: rd_data = pflag_r;
        `T16R_IDX_CNTLO: rd_data = count_lo_r;
        `T16R_IDX_CNTHI: rd_data = count_hi_r;
        `T16R_IDX_TCTL: rd_data = tctl_r & `T16R_TCTL_MASK;
        `T16R_IDX_PEN: rd_data = pen_r;
        `T16R_IDX_TRIG: rd_data = trig_r;
        default: rd_data = 8'h00;
    endcase
    if (!hit)
        rd_data = 8'h00;
end

// ack and registered read data
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
        wb_ack_o <= req;
        if (req && !wb_we_i)
            wb_dat_o <= {24'h00_0000, rd_data};
    end
end

//////////////////////////////////////////////////////////////////////////////
// control registers

// control cleared only by power-on or brown-out reset; rst_i is left out
// on purpose so pin and watchdog resets keep the timer configuration
always @(posedge clk_i)
begin
    if (por_bor_i)
        tctl_r <= `T16R_TCTL_RST; // R7
    else if (wr_tctl) // R8
        tctl_r <= wb_dat_i[7:0] & `T16R_TCTL_MASK;
end

// enables and trigger-mode register follow the system reset
always @(posedge clk_i)
begin
    if (rst_i)
    begin
        pen_r <= `T16R_PEN_RST;
        intctl_r <= `T16R_INTCTL_RST;
        trig_r <= `T16R_TRIG_RST;
    end
    else
    begin
        if (wr_pen)
            pen_r <= wb_dat_i[7:0];
        if (wr_intctl)
            intctl_r <= wb_dat_i[7:0];
        if (wr_trig)
            trig_r <= wb_dat_i[7:0];
    end
end

assign timer_on = tctl_r[`T16R_TCTL_ON];
assign cs_ext = tctl_r[`T16R_TCTL_CS];
assign nsync = tctl_r[`T16R_TCTL_NSYNC];
assign osc_enable_o = tctl_r[`T16R_TCTL_OSCEN];

//////////////////////////////////////////////////////////////////////////////
// tick generation

// instruction-cycle strobe, one clock in four
// free-running: the timer-on bit gates the tick, not this divider
always @(posedge clk_i)
begin
    if (rst_i)
        icyc_r <= 2'h0;
    else
        icyc_r <= icyc_r + 2'h1;
end

assign icyc_tick = (icyc_r == `T16R_ICYC_DIV);

t16r_edge_sync u_sync
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ext_i(ext_clk_i),
    .rise_sync_o(rise_sync),
    .rise_raw_o(rise_raw)
);

// source select: instruction cycles or external edges
// the raw edge path skips the synchroniser, trading safety for latency
assign pre_in = cs_ext ? (nsync ? rise_raw : rise_sync) : icyc_tick; // R11 R13

t16r_prescaler u_pre
(
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(wr_count),
    .tick_i(pre_in && timer_on),
    .ratio_i(tctl_r[`T16R_TCTL_PS_HI:`T16R_TCTL_PS_LO]), // R10
    .tick_o(pre_out)
);

// gated again after the prescaler so a stop freezes the count at once
assign tick = pre_out && timer_on; // R12

//////////////////////////////////////////////////////////////////////////////
// count and trigger clear

assign match_vec = {match_b_i, match_a_i};

// one mode decode per compare unit: unit a field at 3:0, unit b at 7:4
genvar gu;
generate
    for (gu = 0; gu < 2; gu = gu + 1)
    begin : g_unit
        assign trig_hit[gu] = match_vec[gu] && is_special(trig_r[4*gu+3:4*gu]); // R1
    end
endgenerate

// unsynchronised counter mode ignores the clear: that count path is not
// aligned to the bus clock, so a clear there could tear the two bytes
assign trig_ok = !(cs_ext && nsync); // R3
assign trig_clear = (|trig_hit) && trig_ok;
// carry out of bit 15 marks the rollover
assign count_inc = {1'b0, count_hi_r, count_lo_r} + 17'h00001;

// count bytes have no reset term so their contents survive resets; the
// write branch comes first so software beats a trigger in the same cycle
always @(posedge clk_i)
begin
    if (wr_count)
    begin
        if (wr_lo)
            count_lo_r <= wb_dat_i[7:0]; // R4
        if (wr_hi)
            count_hi_r <= wb_dat_i[7:0]; // R4
    end
    else if (trig_clear)
    begin
        count_lo_r <= 8'h00; // R6 R15
        count_hi_r <= 8'h00; // R5 R15
    end
    else if (tick)
    begin
        count_lo_r <= count_inc[7:0];
        count_hi_r <= count_inc[15:8];
    end
end

assign count_o = {count_hi_r, count_lo_r};

// overflow flag: set wins over a software clear; trigger clears never set it
// only an incrementing tick out of all ones counts as an overflow
always @(posedge clk_i)
begin
    if (rst_i)
        pflag_r <= `T16R_PFLAG_RST;
    else
    begin
        if (wr_pflag)
            pflag_r <= wb_dat_i[7:0];
        if (tick && !wr_count && !trig_clear && count_inc[16])
            pflag_r[`T16R_PFLAG_OVF] <= 1'b1; // R14 R2
    end
end

// interrupt request gated by local, peripheral and global enables
assign irq_o = pflag_r[`T16R_PFLAG_OVF] && pen_r[`T16R_PEN_OVF] &&
    intctl_r[`T16R_INTCTL_PERIPH_EN] && intctl_r[`T16R_INTCTL_GLOBAL_EN]; // R14

endmodule

// ===== verif/t16r_ccp_model.sv
`timescale 1ns/100ps
// compare unit: match pulses on alternate clocks while the count meets its pair
module t16r_ccp_model
#(
    parameter [15:0] CMP = 16'h10
)
(
    input wire clk_i,
    input wire [15:0] count_i,
    input wire kick_i,
    output reg match_o = 1'b0
);
    // pulses on alternate cycles, so a held count cannot fire every cycle; kick forces a stray one
    always @(posedge clk_i)
        match_o <= !match_o && (count_i === CMP || kick_i);
endmodule

// ===== verif/t16r_monitor.sv
`timescale 1ns/100ps
`include "t16r_defs.vh"
// bus answers, count moves, control reset
module t16r_monitor
(
    input wire clk_i,
    input wire rst_i,
    input wire por_bor_i,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire [15:0] count_o,
    input wire osc_enable_o
);
    // request taken; cw is a write to either count byte
    wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire cw = take && wb_we_i && wb_sel_i[0] && wb_adr_i[9:3] == 7'h07;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_wr(idx);
        take && wb_we_i && wb_sel_i[0] && wb_adr_i[9:2] == idx;
    endsequence
    property p_ack; take |=> wb_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("no ack");
    property p_one; wb_ack_o |=> !wb_ack_o; endproperty
    a_one: assert property (p_one) else $error("long ack");
    property p_bus; wb_dat_o[31:8] == 24'h0 && !wb_err_o; endproperty
    a_bus: assert property (p_bus) else $error("bad read bits");
    property p_wlo; s_wr(`T16R_IDX_CNTLO) |=> count_o[7:0] == $past(wb_dat_i[7:0]); endproperty
    a_wlo: assert property (p_wlo) else $error("count write lost");
    // only a step, a clear or a write may move the count
    property p_step;
        $changed(count_o) |-> count_o == $past(count_o) + 16'h1 || count_o == 16'h0 || $past(cw);
    endproperty
    a_step: assert property (p_step) else $error("count jumped");
    property p_osc; s_wr(`T16R_IDX_TCTL) |=> osc_enable_o == $past(wb_dat_i[3]); endproperty
    a_osc: assert property (p_osc) else $error("control write lost");
    // these two watch the reset itself, so no disable
    property p_por; disable iff (1'b0) por_bor_i |=> !osc_enable_o; endproperty
    a_por: assert property (p_por) else $error("control kept on power reset");
    property p_keep; disable iff (1'b0) rst_i && !por_bor_i |=> $stable(osc_enable_o); endproperty
    a_keep: assert property (p_keep) else $error("control lost on reset");
endmodule
bind t16r_timer_core t16r_monitor i_t16r_monitor (.*);

// ===== verif/test_t16r_timer_core.sv
`timescale 1ns/100ps
`include "t16r_defs.vh"
module test_t16r_timer_core;
    reg clk_i = 1'b0, rst_i = 1'b1, por = 1'b1, we = 1'b0, stb = 1'b0, ext = 1'b0;
    reg [1:0] kick = 2'h0;
    reg [31:0] adr = 32'h0, wd = 32'h0, rd;
    wire [31:0] rdat;
    wire ack, irq;
    wire [15:0] cnt;
    wire [1:0] mt;
    integer mismatches = 0, checks_done = 0, cycles = 0, seed = 53826, i, n;
    t16r_timer_core i_t16r_timer_core
    (
        .clk_i(clk_i), .rst_i(rst_i), .por_bor_i(por), .wb_adr_i(adr), .wb_dat_i(wd),
        .wb_dat_o(rdat), .wb_sel_i(4'h1), .wb_we_i(we), .wb_cyc_i(stb), .wb_stb_i(stb),
        .wb_ack_o(ack), .wb_err_o(), .ext_clk_i(ext), .match_a_i(mt[0]),
        .match_b_i(mt[1]), .irq_o(irq), .count_o(cnt), .osc_enable_o()
    );
    // unit a matches at 0x10, unit b at 0x18
    t16r_ccp_model #(.CMP(16'h10)) i_t16r_ccp_model_a
        (.clk_i(clk_i), .count_i(cnt), .kick_i(kick[0]), .match_o(mt[0]));
    t16r_ccp_model #(.CMP(16'h18)) i_t16r_ccp_model_b
        (.clk_i(clk_i), .count_i(cnt), .kick_i(kick[1]), .match_o(mt[1]));
    initial
        forever #2 clk_i = ~clk_i;
    // hang guard, far above the run length
    always @(posedge clk_i)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
    ////////////////////
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp)
            begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: %h, want %h", $time, seen, exp);
            end
        end
    endtask
    // one classic cycle, then one idle cycle
    task bus(input w, input [7:0] ix, input [7:0] d);
        begin
            adr <= {22'h0, ix, 2'h0};
            wd <= {24'h0, d};
            we <= w;
            stb <= 1'b1;
            @(posedge clk_i);
            while (ack !== 1'b1)
                @(posedge clk_i);
            rd = rdat;
            stb <= 1'b0;
            @(posedge clk_i);
        end
    endtask
    // no latch between bytes, so only call with the timer stopped
    task setc(input [15:0] v);
        begin
            bus(1, `T16R_IDX_CNTLO, v[7:0]);
            bus(1, `T16R_IDX_CNTHI, v[15:8]);
        end
    endtask
    task test_done;
        begin
            $display("checks %0d, mismatches %0d", checks_done, mismatches);
            if (mismatches == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    ////////////////////
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        por <= 1'b0;
        bus(0, `T16R_IDX_TCTL, 0);
        chk(rd, 0);
        bus(0, 8'h55, 0);
        chk(rd, 0);
        n = $random(seed);
        setc(n[15:0]);
        bus(1, `T16R_IDX_TCTL, 8'h38);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        bus(0, `T16R_IDX_TCTL, 0);
        chk(rd, 32'h38);
        chk(cnt, n[15:0]);
        // power-on reset with the timer stopped: control cleared, count kept
        rst_i <= 1'b1;
        por <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        por <= 1'b0;
        bus(0, `T16R_IDX_TCTL, 0);
        chk(rd, 0);
        chk(cnt, n[15:0]);
        $display("reset done");
        // each ratio over 259 enabled clocks, then hold
        for (i = 0; i < 4; i = i + 1)
        begin
            setc(0);
            bus(1, `T16R_IDX_TCTL, {2'h0, i[1:0], 4'h1});
            repeat (256) @(posedge clk_i);
            bus(1, `T16R_IDX_TCTL, 0);
            rd = cnt;
            repeat (9) @(posedge clk_i);
            n = 259 / (4 << i);
            chk(cnt + 1 >= n && cnt <= n + 1 && cnt == rd, 1);
        end
        $display("prescale done");
        bus(1, `T16R_IDX_PEN, 1);
        bus(1, `T16R_IDX_INTCTL, 8'hc0);
        setc(16'hfffd);
        bus(1, `T16R_IDX_TCTL, 1);
        repeat (20) @(posedge clk_i);
        chk(irq, 1);
        bus(1, `T16R_IDX_PFLAG, 0);
        chk(irq, 0);
        $display("overflow done");
        // no clear, unit a clear, unit b clear
        for (i = 0; i < 3; i = i + 1)
        begin
            bus(1, `T16R_IDX_TCTL, 0);
            bus(1, `T16R_IDX_TRIG, i == 0 ? 8'h00 : i == 1 ? 8'h0b : 8'hb0);
            setc(0);
            bus(1, `T16R_IDX_TCTL, 1);
            n = 0;
            repeat (400)
            begin
                @(posedge clk_i);
                n = cnt > n ? cnt : n;
            end
            chk(i == 0 ? n > 24 : n == 8 + 8 * i, 1);
        end
        // unit b trigger lands on the very tick that would roll over
        bus(1, `T16R_IDX_TCTL, 0);
        setc(16'hfff8);
        bus(1, `T16R_IDX_TCTL, 1);
        while (cnt !== 16'hffff)
            @(posedge clk_i);
        @(posedge clk_i);
        kick <= 2'h2;
        @(posedge clk_i);
        kick <= 2'h0;
        repeat (2) @(posedge clk_i);
        bus(0, `T16R_IDX_PFLAG, 0);
        chk(rd, 0);
        // unit b match lands on the edge that takes the write
        bus(1, `T16R_IDX_TCTL, 0);
        kick <= 2'h2;
        @(posedge clk_i);
        kick <= 2'h0;
        bus(1, `T16R_IDX_CNTLO, 8'h07);
        chk(cnt, 16'h0007);
        $display("trigger done");
        // ten external rises, synchronised then not
        for (i = 0; i < 2; i = i + 1)
        begin
            // on the first pass the rise passes while the timer is still stopped
            ext <= 1'b1;
            setc(0);
            bus(1, `T16R_IDX_TCTL, {5'h0, i[0], 2'h3});
            repeat (20)
            begin
                repeat (6) @(posedge clk_i);
                ext <= ~ext;
            end
            repeat (9) @(posedge clk_i);
            bus(1, `T16R_IDX_TCTL, 0);
            chk(cnt, 10);
        end
        $display("counter done");
        test_done;
    end
endmodule
